// ===== src/sphe_params.svh
// Constants for the shift, pointer and halt execution block.
// Assumes inclusion by bare name from files under src/ and dv/.
`ifndef SPHE_PARAMS_SVH
`define SPHE_PARAMS_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define SPHE_OPC_SHIFT_DIR   8'hd0
`define SPHE_OPC_SHIFT_IND   8'hd1
`define SPHE_OPC_SET_PTR     8'h70
`define SPHE_OPC_NOP         8'hff
`define SPHE_OPC_HALT        8'h6f

// ----------------------------------------------------------------
// Registers, fields and reset values
// ----------------------------------------------------------------
`define SPHE_PTR_ADDR        8'hfd
`define SPHE_PTR_RESET       8'h00
`define SPHE_WORK_NIBBLE     4'he
`define SPHE_RESTART_PC      16'h000c
`define SPHE_FLAG_C          5
`define SPHE_FLAG_Z          4
`define SPHE_FLAG_S          3
`define SPHE_FLAG_V          2
`define SPHE_FLAG_D          1
`define SPHE_FLAG_H          0
`define SPHE_FLAGS_RESET     6'h00

`endif

// ===== src/sphe_pkg.sv
// Types for the shift, pointer and halt execution block.
// Assumes nothing of its surroundings.
package sphe_pkg;

    // Execution sequencer states
    typedef enum logic [2:0] {
        SPHE_FETCH    = 3'b000,
        SPHE_OPERAND  = 3'b001,
        SPHE_READ_PTR = 3'b010,
        SPHE_READ_OPD = 3'b011,
        SPHE_WRITE    = 3'b100,
        SPHE_HALTED   = 3'b101
    } sphe_state_t;

endpackage

// ===== src/sphe_exec.sv
// Execution unit for arithmetic shift right, set pointer and halt.
// Assumes a byte-wide instruction stream with a valid/accept handshake
// and a register file answering reads on the cycle after the request.
`timescale 1ns/1ps
`default_nettype none
`include "sphe_params.svh"

// Summary of operation
// - Shift right; bit0 to carry, bit7 kept
// - Carry equals shifted-out bit zero
// - Zero flag on zero result, sign copies bit7
// - Overflow cleared; decimal and half-carry kept
// - High nibble 1110 selects working register
// - D0 direct shift, D1 indirect shift
// - Set-pointer loads immediate into pointer FD
// - Low nibble zero: high nibble picks group
// - Low nibble nonzero: expanded bank, high ignored
// - Group n maps registers onto n0..nF
// - Direct addressing still reaches standard file
// - Opcode 70 plus immediate is set-pointer
// - Halt stops system and crystal clocks
// - Only reset leaves halt; restart at 000C
// - FF is no-op, 6F is halt
module sphe_exec (
    input  wire logic        core_clk,       // System clock
    input  wire logic        rst_b,          // Async reset, active low
    input  wire logic [7:0]  instr_byte,     // Instruction stream byte
    input  wire logic        instr_valid,    // Stream byte present
    output logic             instr_accept,   // Byte taken this cycle
    output logic [15:0]      pc,             // Program address
    output logic             rf_rd,          // Register read request
    output logic             rf_wr,          // Register write strobe
    output logic [7:0]       rf_addr,        // Standard file address
    output logic             rf_bank_sel,    // Access goes to bank
    output logic [3:0]       rf_bank,        // Expanded bank number
    output logic [7:0]       rf_wdata,       // Write data
    input  wire logic [7:0]  rf_rdata,       // Read data, one cycle
    output logic [7:0]       working_group_pointer, // Pointer at FD
    output logic [5:0]       flags,          // C Z S V D H
    output logic             sys_clk_en,     // System clock running
    output logic             crystal_oscillator_en // Oscillator on
);

    // ------------------------------------------------------------
    // Timing notes
    // ------------------------------------------------------------
    // Stream side:
    //   A byte is taken at a rising edge where instr_valid is high,
    //   instr_accept is low and the sequencer waits for a byte.
    //   instr_accept then stands high for exactly one cycle, and pc
    //   steps by one in that same cycle.
    //   The cycle right after an accept never takes a byte, so the
    //   stream may drop or change its byte while accept is shown.
    //
    // Register file side:
    //   rf_rd is a one-cycle pulse; the file answers on rf_rdata in
    //   the cycle after the pulse has been sampled.
    //   The sequencer therefore waits while rf_rd is still high and
    //   only uses rf_rdata once the pulse has gone low again.
    //   Reading rf_rdata in the pulse cycle itself would pick up a
    //   stale byte from an earlier access.
    //   rf_wr is a one-cycle pulse; address, bank and data stand
    //   with it and are held until the next access.
    //
    // Direct shift, one walk:
    //   opcode taken, accept shown, operand taken, accept shown
    //   together with the read pulse, one cycle of read latency,
    //   then the write pulse with the shifted byte and new flags,
    //   then one cycle back to fetch.
    //
    // Indirect shift:
    //   Same as direct, with one extra read: the first read returns
    //   the operand address, which is used in the standard file as
    //   it stands, without working register resolution.
    //
    // Set pointer:
    //   The pointer takes the immediate byte at the edge where the
    //   immediate is taken; flags are not touched.
    //
    // Halt:
    //   The clock and oscillator enables drop at the edge where the
    //   halt opcode is taken. Nothing more is taken until reset.
    //   A no-op ahead of the halt is the stream's duty; the
    //   sequencer does not check for it.
    //
    // Unknown opcodes:
    //   Taken as single bytes and otherwise ignored, so the stream
    //   never stalls on them.
    //
    // Flags:
    //   Only the shift writes flags; bits D and H are carried over
    //   unchanged by the default assignment at the top of the
    //   next-value process.

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // Resolve a register operand into file address and bank
    function automatic logic [12:0] sphe_resolve(
        input logic [7:0] opd,
        input logic [7:0] ptr
    );
        logic [12:0] r;
        r = {1'b0, 4'h0, opd};
        if (opd[7:4] == `SPHE_WORK_NIBBLE) begin
            if (ptr[3:0] == 4'h0) begin
                r = {1'b0, 4'h0, ptr[7:4], opd[3:0]};
            end else begin
                r = {1'b1, ptr[3:0], 4'h0, opd[3:0]};
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sphe_pkg::sphe_state_t state;       // Sequencer state
    sphe_pkg::sphe_state_t next_state;
    logic [7:0]  opcode;                // Current opcode
    logic [7:0]  next_opcode;
    logic [7:0]  next_working_group_pointer;
    logic [5:0]  next_flags;
    logic [15:0] next_pc;
    logic        next_instr_accept;
    logic        next_rf_rd;
    logic        next_rf_wr;
    logic [7:0]  next_rf_addr;
    logic        next_rf_bank_sel;
    logic [3:0]  next_rf_bank;
    logic [7:0]  next_rf_wdata;
    logic        next_sys_clk_en;
    logic        next_osc_en;
    logic [12:0] res_opd;               // Resolved operand
    logic [7:0]  shifted;               // Shift result

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // Sequencer and datapath next values
    always_comb begin
        next_state       = state;
        next_opcode      = opcode;
        next_working_group_pointer = working_group_pointer;
        next_flags       = flags;
        next_pc          = pc;
        next_instr_accept = 1'b0;
        next_rf_rd       = 1'b0;
        next_rf_wr       = 1'b0;
        next_rf_addr     = rf_addr;
        next_rf_bank_sel = rf_bank_sel;
        next_rf_bank     = rf_bank;
        next_rf_wdata    = rf_wdata;
        next_sys_clk_en  = sys_clk_en;
        next_osc_en      = crystal_oscillator_en;
        res_opd  = sphe_resolve(instr_byte, working_group_pointer);
        shifted  = {rf_rdata[7], rf_rdata[7:1]};
        case (state)
            sphe_pkg::SPHE_FETCH: begin
                // Take an opcode when one is offered
                if (instr_valid && !instr_accept) begin
                    next_instr_accept = 1'b1;
                    next_opcode       = instr_byte;
                    next_pc           = pc + 16'h0001;
                    case (instr_byte)
                        `SPHE_OPC_SHIFT_DIR,
                        `SPHE_OPC_SHIFT_IND,
                        `SPHE_OPC_SET_PTR: begin
                            next_state = sphe_pkg::SPHE_OPERAND;
                        end
                        `SPHE_OPC_HALT: begin
                            // Relies on a preceding no-op
                            next_sys_clk_en = 1'b0;
                            next_osc_en     = 1'b0;
                            next_state      = sphe_pkg::SPHE_HALTED;
                        end
                        default: begin
                            // No-op and other opcodes do nothing here
                        end
                    endcase
                end
            end
            sphe_pkg::SPHE_OPERAND: begin
                // Second byte: operand or immediate
                if (instr_valid && !instr_accept) begin
                    next_instr_accept = 1'b1;
                    next_pc           = pc + 16'h0001;
                    if (opcode == `SPHE_OPC_SET_PTR) begin
                        next_working_group_pointer = instr_byte;
                        next_state = sphe_pkg::SPHE_FETCH;
                    end else begin
                        next_rf_rd       = 1'b1;
                        next_rf_addr     = res_opd[7:0];
                        next_rf_bank_sel = res_opd[12];
                        next_rf_bank     = res_opd[11:8];
                        if (opcode == `SPHE_OPC_SHIFT_IND) begin
                            next_state = sphe_pkg::SPHE_READ_PTR;
                        end else begin
                            next_state = sphe_pkg::SPHE_READ_OPD;
                        end
                    end
                end
            end
            sphe_pkg::SPHE_READ_PTR: begin
                // Register content is the operand address, used in
                // the standard file as it stands
                if (!rf_rd) begin
                    // Read data has arrived
                    next_rf_rd       = 1'b1;
                    next_rf_addr     = rf_rdata;
                    next_rf_bank_sel = 1'b0;
                    next_rf_bank     = 4'h0;
                    next_state       = sphe_pkg::SPHE_READ_OPD;
                end
            end
            sphe_pkg::SPHE_READ_OPD: begin
                // Shift the operand and update flags
                if (!rf_rd) begin
                    // Read data has arrived
                    next_rf_wdata = shifted;
                    next_rf_wr    = 1'b1;
                    next_flags[`SPHE_FLAG_C] = rf_rdata[0];
                    next_flags[`SPHE_FLAG_Z] = (shifted == 8'h00);
                    next_flags[`SPHE_FLAG_S] = shifted[7];
                    next_flags[`SPHE_FLAG_V] = 1'b0;
                    next_state = sphe_pkg::SPHE_WRITE;
                end
            end
            sphe_pkg::SPHE_WRITE: begin
                // Write completes; back to fetch
                next_state = sphe_pkg::SPHE_FETCH;
            end
            sphe_pkg::SPHE_HALTED: begin
                // Only reset leaves this state
                next_state = sphe_pkg::SPHE_HALTED;
            end
            default: begin
                next_state = sphe_pkg::SPHE_FETCH;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Register all state; reset restarts at the fixed address
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state        <= sphe_pkg::SPHE_FETCH;
            opcode       <= `SPHE_OPC_NOP;
            working_group_pointer <= `SPHE_PTR_RESET;
            flags        <= `SPHE_FLAGS_RESET;
            pc           <= `SPHE_RESTART_PC;
            instr_accept <= 1'b0;
            rf_rd        <= 1'b0;
            rf_wr        <= 1'b0;
            rf_addr      <= 8'h00;
            rf_bank_sel  <= 1'b0;
            rf_bank      <= 4'h0;
            rf_wdata     <= 8'h00;
            sys_clk_en   <= 1'b1;
            crystal_oscillator_en <= 1'b1;
        end else begin
            state        <= next_state;
            opcode       <= next_opcode;
            working_group_pointer <= next_working_group_pointer;
            flags        <= next_flags;
            pc           <= next_pc;
            instr_accept <= next_instr_accept;
            rf_rd        <= next_rf_rd;
            rf_wr        <= next_rf_wr;
            rf_addr      <= next_rf_addr;
            rf_bank_sel  <= next_rf_bank_sel;
            rf_bank      <= next_rf_bank;
            rf_wdata     <= next_rf_wdata;
            sys_clk_en   <= next_sys_clk_en;
            crystal_oscillator_en <= next_osc_en;
        end
    end

endmodule
`default_nettype wire

// ===== dv/sphe_regfile_model.sv
// Register file model facing the execution block.
// Assumes one clock; read data is due the cycle after a read.
`timescale 1ns/1ps
`default_nettype none
module sphe_regfile_model (
    input  wire logic       core_clk,
    input  wire logic       rf_rd,
    input  wire logic       rf_wr,
    input  wire logic [7:0] rf_addr,
    input  wire logic       rf_bank_sel,
    input  wire logic [3:0] rf_bank,
    input  wire logic [7:0] rf_wdata,
    output logic      [7:0] rf_rdata
);
    logic [7:0] std_mem  [256]; // Standard file
    logic [7:0] bank_mem [256]; // Banks, indexed {bank, reg}
    initial rf_rdata = 8'h00;
    // ------------------------------------------------------------
    // Access
    // ------------------------------------------------------------
    // Idle read data toggles so stale bytes never look valid
    always @(posedge core_clk) begin
        if (rf_wr && rf_bank_sel)
            bank_mem[{rf_bank, rf_addr[3:0]}] <= rf_wdata;
        else if (rf_wr)
            std_mem[rf_addr] <= rf_wdata;
        if (rf_rd && rf_bank_sel)
            rf_rdata <= bank_mem[{rf_bank, rf_addr[3:0]}];
        else if (rf_rd)
            rf_rdata <= std_mem[rf_addr];
        else
            rf_rdata <= ~rf_rdata;
    end
endmodule
`default_nettype wire

// ===== dv/sphe_exec_assertions.sv
// Checker for the shift, pointer and halt execution block.
// Assumes it is bound onto sphe_exec; one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "sphe_params.svh"
module sphe_exec_assertions (
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic [7:0] instr_byte,
    input wire logic       instr_accept,
    input wire logic       rf_rd,
    input wire logic       rf_wr,
    input wire logic [7:0] rf_wdata,
    input wire logic [7:0] rf_rdata,
    input wire logic [7:0] working_group_pointer,
    input wire logic [5:0] flags,
    input wire logic       sys_clk_en,
    input wire logic       crystal_oscillator_en
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // Shift results, written one cycle after the operand arrives
    // ------------------------------------------------------------
    shift_value_a: assert property (
        rf_wr |-> rf_wdata == {$past(rf_rdata[7]), $past(rf_rdata[7:1])})
        else $error("shift result wrong");
    carry_out_a: assert property (
        rf_wr |-> flags[`SPHE_FLAG_C] == $past(rf_rdata[0]))
        else $error("carry wrong");
    zero_sign_a: assert property (
        rf_wr |-> flags[`SPHE_FLAG_Z] == (rf_wdata == 8'h00)
            && flags[`SPHE_FLAG_S] == rf_wdata[7])
        else $error("zero or sign wrong");
    ovf_clear_a: assert property (
        rf_wr |-> !flags[`SPHE_FLAG_V] && $stable(flags[1:0]))
        else $error("overflow, decimal or half wrong");
    read_first_a: assert property (
        rf_wr |-> $past(rf_rd, 2))
        else $error("write without read");
    // ------------------------------------------------------------
    // Pointer and halt
    // ------------------------------------------------------------
    ptr_load_a: assert property (
        $changed(working_group_pointer) |-> instr_accept
            && working_group_pointer == $past(instr_byte))
        else $error("pointer load wrong");
    ptr_flags_a: assert property (
        $changed(working_group_pointer) |-> $stable(flags))
        else $error("flags moved on pointer load");
    halt_clocks_a: assert property (
        !sys_clk_en |-> !crystal_oscillator_en)
        else $error("oscillator left running");
    halt_hold_a: assert property (
        !sys_clk_en |=> !sys_clk_en && !instr_accept && !rf_wr)
        else $error("halt left without reset");
    cover property (rf_wr && rf_wdata[7]);
    cover property ($changed(working_group_pointer));
    cover property ($fell(sys_clk_en));
endmodule
bind sphe_exec sphe_exec_assertions sphe_exec_assertions_inst (
    .core_clk(core_clk), .rst_b(rst_b), .instr_byte(instr_byte),
    .instr_accept(instr_accept), .rf_rd(rf_rd), .rf_wr(rf_wr),
    .rf_wdata(rf_wdata), .rf_rdata(rf_rdata), .flags(flags),
    .working_group_pointer(working_group_pointer),
    .sys_clk_en(sys_clk_en), .crystal_oscillator_en(crystal_oscillator_en));
`default_nettype wire

// ===== dv/shift_pointer_halt_exec_bench.sv
// Self-checking bench for the shift, pointer and halt block.
// Assumes sphe_exec and the register file model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "sphe_params.svh"
module shift_pointer_halt_exec_bench;
    logic        core_clk, rst_b, instr_valid, instr_accept, osc;
    logic        rf_rd, rf_wr, rf_bank_sel, sys_clk_en;
    logic [7:0]  instr_byte, rf_addr, rf_wdata, rf_rdata, ptr;
    logic [7:0]  v, a, p, t, bm, got;
    logic [3:0]  rf_bank, g, lo;
    logic [5:0]  flags, ef;
    logic [15:0] pc, ep;
    logic [7:0]  corner [4] = '{8'h00, 8'h01, 8'h80, 8'hff};
    int          mismatches = 0;
    int          samples_checked = 0;
    sphe_exec sphe_exec_inst (.core_clk(core_clk), .rst_b(rst_b),
        .instr_byte(instr_byte), .instr_valid(instr_valid),
        .instr_accept(instr_accept), .pc(pc), .rf_rd(rf_rd), .rf_wr(rf_wr),
        .rf_addr(rf_addr), .rf_bank_sel(rf_bank_sel), .rf_bank(rf_bank),
        .rf_wdata(rf_wdata), .rf_rdata(rf_rdata), .flags(flags),
        .working_group_pointer(ptr), .sys_clk_en(sys_clk_en),
        .crystal_oscillator_en(osc));
    sphe_regfile_model sphe_regfile_model_inst (.core_clk(core_clk),
        .rf_rd(rf_rd), .rf_wr(rf_wr), .rf_addr(rf_addr),
        .rf_bank_sel(rf_bank_sel), .rf_bank(rf_bank),
        .rf_wdata(rf_wdata), .rf_rdata(rf_rdata));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] arith_shift_right_op(input logic [7:0] x);
        return {x[7], x[7:1]};
    endfunction
    task automatic check(input string s, input logic [15:0] e,
                         input logic [15:0] q);
        samples_checked++;
        if (q !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", s, e, q);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Bound ran out: count it and stop
    task automatic expire(input int n);
        if (n >= 20) begin
            mismatches++;
            wrap_up();
        end
    endtask
    // Offer one byte, hold it until accept shows
    task automatic send(input logic [7:0] b);
        int n;
        @(negedge core_clk);
        instr_byte = b;
        instr_valid = 1'b1;
        for (n = 0; n < 20 && instr_accept !== 1'b1; n++)
            @(negedge core_clk);
        instr_valid = 1'b0;
        expire(n);
        ep = ep + 16'h0001;
        check("pc", ep, pc);
    endtask
    // Opcode, operand, then wait for the write-back
    task automatic shift(input logic [7:0] op, input logic [7:0] opd);
        int n;
        send(op);
        send(opd);
        for (n = 0; n < 20 && rf_wr !== 1'b1; n++)
            @(negedge core_clk);
        expire(n);
        @(negedge core_clk);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        instr_valid = 1'b0;
        instr_byte = 8'h00;
        ef = 6'h00;
        ep = 16'h000c;
        void'($urandom(32'hd7861059));
        repeat (2) @(negedge core_clk);
        rst_b = 1'b1;
        // Modes: group reg, bank reg, direct, indirect
        for (int i = 0; i < 16; i++) begin
            g = 4'($urandom);
            lo = (i % 4 == 0) ? 4'h0 : 4'($urandom_range(15, 1));
            v = (i < 4) ? corner[i] : 8'($urandom);
            a = {4'($urandom_range(13, 0)), 4'($urandom)};
            p = a ^ 8'h80;
            t = (i % 4 == 0) ? {g, a[3:0]} : (i % 4 == 3) ? p : a;
            bm = {lo, a[3:0]};
            send(`SPHE_OPC_SET_PTR);
            send({g, lo});
            check("pointer", {g, lo}, ptr);
            check("flags kept", ef, flags);
            if (i % 4 == 1)
                sphe_regfile_model_inst.bank_mem[bm] = v;
            else
                sphe_regfile_model_inst.std_mem[t] = v;
            if (i % 4 == 3)
                sphe_regfile_model_inst.std_mem[a] = p;
            shift((i % 4 == 3) ? `SPHE_OPC_SHIFT_IND : `SPHE_OPC_SHIFT_DIR,
                  (i % 4 < 2) ? {4'he, a[3:0]} : a);
            got = (i % 4 == 1) ? sphe_regfile_model_inst.bank_mem[bm]
                               : sphe_regfile_model_inst.std_mem[t];
            ef = {v[0], arith_shift_right_op(v) == 8'h00, v[7], 1'b0, ef[1:0]};
            check("shifted byte", arith_shift_right_op(v), got);
            check("flags", ef, flags);
            $display("shift test %0d mode %0d done", i, i % 4);
        end
        send(`SPHE_OPC_NOP);
        check("flags after no-op", ef, flags);
        send(`SPHE_OPC_HALT);
        check("clock enable", 16'h0000, sys_clk_en);
        check("oscillator", 16'h0000, osc);
        repeat (6) begin
            @(negedge core_clk);
            instr_valid = 1'b1;
            check("held in halt", 16'h0000, instr_accept);
        end
        rst_b = 1'b0;
        instr_valid = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_b = 1'b1;
        check("clock back", 16'h0001, sys_clk_en);
        ep = 16'h000c;
        send(`SPHE_OPC_NOP);
        $display("halt test done");
        wrap_up();
    end
endmodule
`default_nettype wire
